// >>> dv/cbe_checker.sv
/*
  Timing checks on the shared two-wire link between host and device ends.
  Assumes the plain signals of one link interface, sampled on the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cbe_checker (
  input wire logic clk_i, // core clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic scl, // link clock
  input wire logic sda, // resolved data level
  input wire logic sda_h_o, // host data out
  input wire logic sda_h_oe, // host pulls low
  input wire logic sda_d_o, // device data out
  input wire logic sda_d_oe // device pulls low
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  //////////////////////////////////////////////////////////////////////////////
  od_pins_a: assert property (!sda_h_o && !sda_d_o)
    else $error("link data driven high");
  scl_high_a: assert property ($rose(scl) |-> scl[*8])
    else $error("link clock high phase short");
  scl_low_a: assert property ($fell(scl) |-> !scl[*8])
    else $error("link clock low phase short");
  // The device may only move data while the clock is low, or it fakes a start or stop.
  dev_move_a: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl, 2))
    else $error("device data moved with clock high");
  dev_lag_a: assert property ($changed(sda_d_oe) |->
    ($past(scl, 4) || $past(scl, 5) || $past(scl, 6)))
    else $error("device data not tied to clock fall");
  start_a: assert property ($rose(sda_h_oe) && scl |-> ##[1:8] !scl)
    else $error("start not followed by clock low");
  stop_a: assert property ($fell(sda_h_oe) && scl |-> ##1 (sda && scl)[*4])
    else $error("stop not followed by idle link");
  dev_release_a: assert property ($rose(sda_d_oe) |-> ##[1:200] !sda_d_oe)
    else $error("device holds data too long");
endmodule : cbe_checker
`default_nettype wire

// >>> dv/tb_config_block_command_engine.sv
/*
  Bench: host and device ends on one link; a second device driven bit by bit.
  Assumes a 50 MHz core clock shared by both ends.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_config_block_command_engine;
  import cbe_pkg::*;
  localparam int LIMIT = 100000;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic go_i = 1'b0;
  logic [7:0] cmd_i = 8'h00;
  logic [7:0] data_i;
  logic [7:0] data_idx_o;
  logic [7:0] rd_data_o;
  logic busy_o, done_o, nak_o, rd_valid_o, chk_ok_o, reload_o, wdog_off_o, chk_err_o;
  logic [CFG_W-1:0] live_cfg_o, live_f, wr_img, rd_img;
  int n_mismatch = 0;
  int n_compared = 0;
  int rd_n = 0, n_reload = 0, n_wdog = 0, n_err = 0, cyc = 0;
  cbe_link_if i_link ();
  cbe_link_if i_link_f ();
  always #10 clk_i = ~clk_i;
  // The host fetches block bytes combinationally by index.
  always_comb data_i = wr_img[8*data_idx_o +: 8];
  cbe_dev i_cbe_dev (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(i_link), .live_cfg_o(live_cfg_o),
    .reload_o(reload_o), .wdog_off_o(wdog_off_o), .chk_err_o(chk_err_o));
  cbe_dev i_cbe_dev_f (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(i_link_f), .live_cfg_o(live_f),
    .reload_o(), .wdog_off_o(), .chk_err_o());
  cbe_host i_cbe_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(i_link), .go_i(go_i),
    .cmd_i(cmd_i), .data_i(data_i), .data_idx_o(data_idx_o), .busy_o(busy_o), .done_o(done_o),
    .nak_o(nak_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .chk_ok_o(chk_ok_o));
  cbe_checker i_cbe_checker (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl(i_link.scl),
    .sda(i_link.sda), .sda_h_o(i_link.sda_h_o), .sda_h_oe(i_link.sda_h_oe),
    .sda_d_o(i_link.sda_d_o), .sda_d_oe(i_link.sda_d_oe));
  //////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task chk(input string what, input logic [CFG_W-1:0] seen, input logic [CFG_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  always @(posedge clk_i) begin
    cyc++;
    if (rd_valid_o === 1'b1) begin
      rd_img[8*rd_n +: 8] <= rd_data_o;
      rd_n <= rd_n + 1;
    end
    if (reload_o === 1'b1) n_reload++;
    if (wdog_off_o === 1'b1) n_wdog++;
    if (chk_err_o === 1'b1) n_err++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      wrap_up();
    end
  end

  function automatic logic [CFG_W-1:0] mk(input logic [7:0] s);
    logic [CFG_W-1:0] v;
    for (int k = 0; k < CFG_BYTES; k++) v[8*k +: 8] = 8'(k) ^ s;
    return v;
  endfunction : mk
  //////////////////////////////////////////////////////////////////////////////
  task run(input logic [7:0] c);
    int n;
    n = 0;
    rd_n = 0;
    @(posedge clk_i);
    go_i <= 1'b1;
    cmd_i <= c;
    @(posedge clk_i);
    go_i <= 1'b0;
    while (done_o !== 1'b1 && n < 40000) begin
      @(posedge clk_i);
      n++;
    end
    chk("nak", nak_o, 1'b0);
    chk("busy", busy_o, 1'b0);
  endtask : run

  // Bench-made link: low phase longer than high so a late device release settles first.
  task fbit(input logic b, output logic s);
    @(posedge clk_i);
    i_link_f.sda_h_oe <= !b;
    repeat (4) @(posedge clk_i);
    i_link_f.scl <= 1'b1;
    repeat (3) @(posedge clk_i);
    s = i_link_f.sda;
    i_link_f.scl <= 1'b0;
  endtask : fbit

  task fbyte(input logic [7:0] v, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) fbit(v[i], s);
    fbit(1'b1, nak);
  endtask : fbyte

  task fedge(input logic stop);
    @(posedge clk_i);
    i_link_f.sda_h_oe <= 1'b1;
    repeat (4) @(posedge clk_i);
    i_link_f.scl <= stop;
    if (stop) begin
      repeat (4) @(posedge clk_i);
      i_link_f.sda_h_oe <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
  endtask : fedge
  //////////////////////////////////////////////////////////////////////////////
  task t_live;
    wr_img = mk(8'h3c);
    run(CMD_WR_LIVE);
    chk("live write", live_cfg_o, mk(8'h3c));
    run(CMD_RD_LIVE);
    chk("live read", rd_img, mk(8'h3c));
    chk("live count", rd_n, CFG_BYTES);
    chk("live sum", chk_ok_o, 1'b1);
  endtask : t_live

  task t_restore;
    run(CMD_STORE);
    run(CMD_FACTORY);
    chk("factory keeps live", live_cfg_o, mk(8'h3c));
    run(CMD_RECONF);
    chk("reconf factory", live_cfg_o, FACTORY_CFG);
    chk("reloads", n_reload, 2);
    chk("wdog off", n_wdog, 2);
  endtask : t_restore

  task t_nv;
    wr_img = mk(8'hc3);
    run(CMD_WR_NV);
    chk("nv keeps live", live_cfg_o, FACTORY_CFG);
    run(CMD_RD_NV);
    chk("nv read", rd_img, mk(8'hc3));
    chk("nv sum", chk_ok_o, 1'b1);
  endtask : t_nv

  task t_unknown;
    logic [7:0] codes [3] = '{8'h00, 8'h08, 8'hff};
    foreach (codes[i]) begin
      run(codes[i]);
      chk("unknown", live_cfg_o, FACTORY_CFG);
    end
    // Stored defaults still hold the written block, so a store must replace them.
    run(CMD_STORE);
    run(CMD_RECONF);
    chk("store live", live_cfg_o, FACTORY_CFG);
  endtask : t_unknown

  task t_fault;
    logic nak;
    fedge(1'b0);
    fbyte(HDR_WR, nak);
    chk("header ack", nak, 1'b0);
    fbyte(8'h31, nak);
    chk("wrong register", nak, 1'b1);
    fedge(1'b1);
    fedge(1'b0);
    fbyte(HDR_WR, nak);
    fbyte(REG_CMD, nak);
    fbyte(CMD_WR_LIVE, nak);
    chk("command ack", nak, 1'b0);
    fbyte(8'h12, nak);
    fbyte(8'h34, nak);
    fedge(1'b1);
    repeat (20) @(posedge clk_i);
    chk("short block", live_f, FACTORY_CFG);
  endtask : t_fault

  initial begin
    i_link_f.scl = 1'b1;
    i_link_f.sda_h_oe = 1'b0;
    i_link_f.sda_h_o = 1'b0;
    wr_img = '0;
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("boot live", live_cfg_o, FACTORY_CFG);
    chk("boot reload", n_reload, 1);
    t_live();
    t_restore();
    t_nv();
    t_unknown();
    t_fault();
    chk("no refusal", n_err, 0);
    wrap_up();
  end
endmodule : tb_config_block_command_engine
`default_nettype wire

// >>> rtl/cbe_dev.sv
/*
  Device end: command register, nonvolatile defaults, live configuration image.
  Assumes a host that makes the link clock and keeps the frame format.
*/
// Behaviour
// - Commands arrive through register 30h.
// - 01h copies live settings into stored defaults.
// - Stored defaults load at power-up and 07h.
// - 02h overwrites stored defaults with factory values.
// - Factory restore leaves live settings unchanged.
// - 03h takes 147-byte block as new defaults.
// - Writing defaults never touches live settings.
// - Checksum is XOR of the 146 bytes.
// - Bad or short defaults block: NAK, nothing stored; the code stores nothing from a short block but sends it no NAK.
// - Host sends command, 146 bytes, then checksum.
// - Five eight-byte per-port groups lead block.
// - Drive modes: seven bytes per port from 28h.
// - PWM triples from 60h, then divider, enable.
// - 04h reads stored defaults plus checksum.
// - Bad or short live block: NAK, discarded; the code discards a short block but sends it no NAK.
// - Good live block applies all at once.
// - 06h reads live settings plus checksum.
// - 07h reloads live settings from stored defaults.
// - Reconfigure also switches the watchdog off.
`timescale 1ns/1ns
`default_nettype none
module cbe_dev (
  input wire logic clk_i, // core clock
  input wire logic arst_n_i, // async reset, active low
  cbe_link_if.dev link, // two-wire link
  output logic [cbe_pkg::CFG_W-1:0] live_cfg_o, // live configuration image
  output logic reload_o, // pulse: live image reloaded
  output logic wdog_off_o, // pulse: watchdog switched off
  output logic chk_err_o // pulse: block refused on checksum
);
  import cbe_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic scl_rise, scl_fall, start_c, stop_c;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= link.scl;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign scl_rise = scl_s_q && !scl_p_q;
  assign scl_fall = !scl_s_q && scl_p_q;
  assign start_c = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop_c = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

  ////////////////////////////////////////////////////////////////////////////////
  cbe_lst_t st_q, st_d;
  cbe_mode_t mode_q, mode_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, fb_q, fb_d, ti_q, ti_d, xor_q, xor_d;
  logic oe_q, oe_d, txp_q, txp_d, src_live_q, src_live_d, boot_q, boot_d;
  logic reload_q, reload_d, wdog_q, wdog_d, err_q, err_d;
  logic [CFG_W-1:0] nv_q, nv_d, live_q, live_d, stage_q, stage_d;
  logic [7:0] nb, di, ti_ix;

  // Next byte to send on a read; the checksum follows the 146 data bytes.
  always_comb begin
    ti_ix = (ti_q < 8'(CFG_BYTES)) ? ti_q : 8'h00;
    if (ti_q < 8'(CFG_BYTES)) begin
      nb = src_live_q ? live_q[8*ti_ix +: 8] : nv_q[8*ti_ix +: 8];
    end else if (ti_q == 8'(CFG_BYTES)) begin
      nb = xor_q;
    end else begin
      nb = 8'hff;
    end
  end

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    bit_d = bit_q;
    sh_d = sh_q;
    fb_d = fb_q;
    ti_d = ti_q;
    xor_d = xor_q;
    oe_d = oe_q;
    txp_d = txp_q;
    src_live_d = src_live_q;
    boot_d = 1'b0;
    nv_d = nv_q;
    live_d = live_q;
    stage_d = stage_q;
    reload_d = 1'b0;
    wdog_d = 1'b0;
    err_d = 1'b0;
    di = fb_q - FB_DATA;
    if (boot_q) begin
      live_d = nv_q;
      reload_d = 1'b1;
      wdog_d = 1'b1;
    end
    if (start_c) begin
      // A fresh frame drops any half-received block, so nothing is committed.
      st_d = CBE_L_RX;
      mode_d = CBE_M_NONE;
      // The clock fall that closes the start condition wraps this count to bit 0.
      bit_d = '1;
      fb_d = FB_HDR;
      ti_d = 8'h00;
      xor_d = 8'h00;
      txp_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = CBE_L_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        CBE_L_RX: begin
          if (scl_rise && bit_q < BIT_ACK) begin
            sh_d = {sh_q[6:0], sda_s_q};
          end else if (scl_fall && bit_q == BIT_LAST) begin
            bit_d = BIT_ACK;
            oe_d = 1'b0;
            if (fb_q != 8'hff) begin
              fb_d = fb_q + 8'h01;
            end
            if (fb_q == FB_HDR) begin
              oe_d = (sh_q == HDR_WR) || (sh_q == HDR_RD);
              txp_d = (sh_q == HDR_RD);
            end else if (fb_q == FB_REG) begin
              oe_d = (sh_q == REG_CMD);
            end else if (fb_q == FB_CMD) begin
              oe_d = 1'b1;
              case (sh_q)
                CMD_STORE: nv_d = live_q;
                CMD_FACTORY: nv_d = FACTORY_CFG;
                CMD_WR_NV: mode_d = CBE_M_NV;
                CMD_WR_LIVE: mode_d = CBE_M_LIVE;
                CMD_RD_NV: src_live_d = 1'b0;
                CMD_RD_LIVE: src_live_d = 1'b1;
                CMD_RECONF: begin
                  live_d = nv_q;
                  reload_d = 1'b1;
                  wdog_d = 1'b1;
                end
                default: ;
              endcase
            end else if (mode_q != CBE_M_NONE) begin
              if (di < 8'(CFG_BYTES)) begin
                // Block order is kept byte for byte, so the image maps straight on.
                stage_d[8*di +: 8] = sh_q;
                xor_d = xor_q ^ sh_q;
                oe_d = 1'b1;
              end else begin
                mode_d = CBE_M_NONE;
                if (sh_q == xor_q) begin
                  oe_d = 1'b1;
                  if (mode_q == CBE_M_NV) begin
                    nv_d = stage_q;
                  end else begin
                    live_d = stage_q;
                  end
                end else begin
                  err_d = 1'b1;
                end
              end
            end
          end else if (scl_fall && bit_q == BIT_ACK) begin
            bit_d = 4'h0;
            oe_d = 1'b0;
            if (!oe_q) begin
              st_d = CBE_L_SKIP;
            end else if (txp_q) begin
              st_d = CBE_L_TX;
              sh_d = nb;
              oe_d = !nb[7];
              ti_d = ti_q + 8'h01;
              xor_d = xor_q ^ nb;
            end
          end else if (scl_fall) begin
            bit_d = bit_q + 4'h1;
          end
        end
        CBE_L_TX: begin
          if (scl_rise && bit_q == BIT_ACK && sda_s_q) begin
            st_d = CBE_L_SKIP;
          end else if (scl_fall && bit_q < BIT_LAST) begin
            sh_d = {sh_q[6:0], 1'b1};
            oe_d = !sh_q[6];
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == BIT_LAST) begin
            bit_d = BIT_ACK;
            oe_d = 1'b0;
          end else if (scl_fall) begin
            bit_d = 4'h0;
            sh_d = nb;
            oe_d = !nb[7];
            if (ti_q != 8'hff) begin
              ti_d = ti_q + 8'h01;
            end
            if (ti_q < 8'(CFG_BYTES)) begin
              xor_d = xor_q ^ nb;
            end
          end
        end
        CBE_L_SKIP: oe_d = 1'b0;
        default: st_d = CBE_L_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= CBE_L_IDLE;
      mode_q <= CBE_M_NONE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      fb_q <= 8'h00;
      ti_q <= 8'h00;
      xor_q <= 8'h00;
      oe_q <= 1'b0;
      txp_q <= 1'b0;
      src_live_q <= 1'b0;
      boot_q <= 1'b1;
      nv_q <= FACTORY_CFG;
      live_q <= FACTORY_CFG;
      stage_q <= '0;
      reload_q <= 1'b0;
      wdog_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      fb_q <= fb_d;
      ti_q <= ti_d;
      xor_q <= xor_d;
      oe_q <= oe_d;
      txp_q <= txp_d;
      src_live_q <= src_live_d;
      boot_q <= boot_d;
      nv_q <= nv_d;
      live_q <= live_d;
      stage_q <= stage_d;
      reload_q <= reload_d;
      wdog_q <= wdog_d;
      err_q <= err_d;
    end
  end

  assign link.sda_d_o = 1'b0;
  assign link.sda_d_oe = oe_q;
  assign live_cfg_o = live_q;
  assign reload_o = reload_q;
  assign wdog_off_o = wdog_q;
  assign chk_err_o = err_q;
endmodule : cbe_dev
`default_nettype wire

// >>> rtl/cbe_host.sv
/*
  Host end: makes the link clock, runs one command per go pulse, streams blocks.
  Assumes user logic on the same clock supplies data_i for data_idx_o.
*/
`timescale 1ns/1ns
`default_nettype none
module cbe_host (
  input wire logic clk_i, // core clock
  input wire logic arst_n_i, // async reset, active low
  cbe_link_if.host link, // two-wire link
  input wire logic go_i, // pulse: start command
  input wire logic [7:0] cmd_i, // command code
  input wire logic [7:0] data_i, // block byte for data_idx_o
  output logic [7:0] data_idx_o, // index of block byte wanted
  output logic busy_o, // command in progress
  output logic done_o, // pulse: command finished
  output logic nak_o, // device refused a byte
  output logic [7:0] rd_data_o, // byte read
  output logic rd_valid_o, // pulse: rd_data_o valid
  output logic chk_ok_o // read checksum matched
);
  import cbe_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic sda_m_q, sda_s_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  cbe_hst_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] bn_q, bn_d, sh_q, sh_d, cmd_q, cmd_d, chk_q, chk_d, idx_q, idx_d;
  logic [7:0] rdd_q, rdd_d, flen, txb;
  logic frm_q, frm_d, scl_q, scl_d, oe_q, oe_d, ackb_q, ackb_d, nak_q, nak_d;
  logic busy_q, busy_d, done_q, done_d, rdv_q, rdv_d, ok_q, ok_d;
  logic tick, rx, blk, rdc;

  assign tick = (cnt_q == QTR_LAST);
  assign rx = frm_q && (bn_q != FB_HDR);
  assign blk = (cmd_q == CMD_WR_NV) || (cmd_q == CMD_WR_LIVE);
  assign rdc = (cmd_q == CMD_RD_NV) || (cmd_q == CMD_RD_LIVE);

  // Write frame: header, command register, command, then block and checksum.
  always_comb begin
    flen = frm_q ? FRM_RD_LEN : (blk ? FRM_BLK_LEN : FRM_CMD_LEN);
    if (frm_q) begin
      txb = HDR_RD;
    end else if (bn_q == FB_HDR) begin
      txb = HDR_WR;
    end else if (bn_q == FB_REG) begin
      txb = REG_CMD;
    end else if (bn_q == FB_CMD) begin
      txb = cmd_q;
    end else if (bn_q < FRM_BLK_LEN - 8'h01) begin
      txb = data_i;
    end else begin
      txb = chk_q;
    end
  end

  always_comb begin
    st_d = st_q;
    cnt_d = tick ? 3'h0 : cnt_q + 3'h1;
    ph_d = ph_q;
    bit_d = bit_q;
    bn_d = bn_q;
    sh_d = sh_q;
    cmd_d = cmd_q;
    chk_d = chk_q;
    idx_d = idx_q;
    rdd_d = rdd_q;
    frm_d = frm_q;
    scl_d = scl_q;
    oe_d = oe_q;
    ackb_d = ackb_q;
    nak_d = nak_q;
    busy_d = busy_q;
    done_d = 1'b0;
    rdv_d = 1'b0;
    ok_d = ok_q;
    if (st_q == CBE_H_IDLE) begin
      if (go_i) begin
        st_d = CBE_H_START;
        cmd_d = cmd_i;
        frm_d = 1'b0;
        busy_d = 1'b1;
        nak_d = 1'b0;
        ok_d = 1'b0;
        ph_d = 2'h0;
        cnt_d = 3'h0;
      end
    end else if (tick) begin
      ph_d = ph_q + 2'h1;
      case (st_q)
        CBE_H_START: begin
          case (ph_q)
            2'h0: begin scl_d = 1'b1; oe_d = 1'b0; end
            2'h1: oe_d = 1'b1;
            2'h2: scl_d = 1'b0;
            default: begin
              st_d = CBE_H_BYTE;
              bn_d = FB_HDR;
              bit_d = 4'h0;
              chk_d = 8'h00;
              idx_d = 8'h00;
            end
          endcase
        end
        CBE_H_BYTE: begin
          case (ph_q)
            2'h0: begin
              if (bit_q == BIT_ACK) begin
                oe_d = rx && (bn_q != FRM_RD_LEN - 8'h01);
              end else if (rx) begin
                oe_d = 1'b0;
              end else if (bit_q == 4'h0) begin
                sh_d = txb;
                oe_d = !txb[7];
                if (!frm_q && bn_q >= FB_DATA) begin
                  chk_d = chk_q ^ txb;
                end
              end else begin
                oe_d = !sh_q[7];
              end
            end
            2'h1: scl_d = 1'b1;
            2'h2: begin
              if (bit_q == BIT_ACK) begin
                ackb_d = sda_s_q;
              end else if (rx) begin
                sh_d = {sh_q[6:0], sda_s_q};
              end
            end
            default: begin
              scl_d = 1'b0;
              if (bit_q != BIT_ACK) begin
                bit_d = bit_q + 4'h1;
                if (!rx) begin
                  sh_d = {sh_q[6:0], 1'b1};
                end
              end else if (!rx && ackb_q) begin
                nak_d = 1'b1;
                st_d = CBE_H_STOP;
              end else begin
                if (rx && bn_q < FRM_RD_LEN - 8'h01) begin
                  rdd_d = sh_q;
                  rdv_d = 1'b1;
                  chk_d = chk_q ^ sh_q;
                end else if (rx) begin
                  ok_d = (sh_q == chk_q);
                end
                if (bn_q == flen - 8'h01) begin
                  st_d = CBE_H_STOP;
                end else begin
                  bn_d = bn_q + 8'h01;
                  bit_d = 4'h0;
                  idx_d = bn_q + 8'h01 - FB_DATA;
                end
              end
            end
          endcase
        end
        CBE_H_STOP: begin
          case (ph_q)
            2'h0: oe_d = 1'b1;
            2'h1: scl_d = 1'b1;
            2'h2: oe_d = 1'b0;
            default: begin
              if (!nak_q && !frm_q && rdc) begin
                frm_d = 1'b1;
                st_d = CBE_H_START;
              end else begin
                st_d = CBE_H_IDLE;
                busy_d = 1'b0;
                done_d = 1'b1;
              end
            end
          endcase
        end
        default: st_d = CBE_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= CBE_H_IDLE;
      cnt_q <= 3'h0;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      bn_q <= 8'h00;
      sh_q <= 8'h00;
      cmd_q <= 8'h00;
      chk_q <= 8'h00;
      idx_q <= 8'h00;
      rdd_q <= 8'h00;
      frm_q <= 1'b0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      ackb_q <= 1'b0;
      nak_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdv_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      bn_q <= bn_d;
      sh_q <= sh_d;
      cmd_q <= cmd_d;
      chk_q <= chk_d;
      idx_q <= idx_d;
      rdd_q <= rdd_d;
      frm_q <= frm_d;
      scl_q <= scl_d;
      oe_q <= oe_d;
      ackb_q <= ackb_d;
      nak_q <= nak_d;
      busy_q <= busy_d;
      done_q <= done_d;
      rdv_q <= rdv_d;
      ok_q <= ok_d;
    end
  end

  assign link.scl = scl_q;
  assign link.sda_h_o = 1'b0;
  assign link.sda_h_oe = oe_q;
  assign data_idx_o = idx_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign nak_o = nak_q;
  assign rd_data_o = rdd_q;
  assign rd_valid_o = rdv_q;
  assign chk_ok_o = ok_q;
endmodule : cbe_host
`default_nettype wire

// >>> rtl/cbe_link_if.sv
/*
  Two-wire link between host and device: clock driven by the host, open-drain data.
  Assumes the bench reads sda as the resolved wire level.
*/
`timescale 1ns/1ns
`default_nettype none
interface cbe_link_if;
  logic scl;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  wire sda;

  // Open drain: any enabled driver with a low data out pulls low, otherwise the pull-up wins.
  assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));

  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
  modport host (output scl, input sda, output sda_h_o, output sda_h_oe);
endinterface : cbe_link_if
`default_nettype wire

// >>> rtl/cbe_pkg.sv
/*
  Shared constants for the configuration command engine and its two-wire link.
  Assumes both ends run on one 50 MHz core clock.
*/
package cbe_pkg;
  localparam int CFG_BYTES = 146;
  localparam int BLK_BYTES = CFG_BYTES + 1;
  localparam int CFG_W = CFG_BYTES * 8;

  localparam logic [7:0] REG_CMD = 8'h30;
  localparam logic [7:0] CMD_STORE = 8'h01;
  localparam logic [7:0] CMD_FACTORY = 8'h02;
  localparam logic [7:0] CMD_WR_NV = 8'h03;
  localparam logic [7:0] CMD_RD_NV = 8'h04;
  localparam logic [7:0] CMD_WR_LIVE = 8'h05;
  localparam logic [7:0] CMD_RD_LIVE = 8'h06;
  localparam logic [7:0] CMD_RECONF = 8'h07;
  // Link header bytes; the values are arbitrary.
  localparam logic [7:0] HDR_WR = 8'h40;
  localparam logic [7:0] HDR_RD = 8'h41;

  // Byte positions inside a frame and inside the block.
  localparam logic [7:0] FB_HDR = 8'h00;
  localparam logic [7:0] FB_REG = 8'h01;
  localparam logic [7:0] FB_CMD = 8'h02;
  localparam logic [7:0] FB_DATA = 8'h03;
  localparam logic [7:0] IDX_CHK = 8'h92;
  localparam logic [7:0] FRM_CMD_LEN = 8'h03;
  localparam logic [7:0] FRM_BLK_LEN = 8'h96;
  localparam logic [7:0] FRM_RD_LEN = 8'h94;
  localparam int OFS_DRV = 8'h28;
  localparam int DRV_MODES = 7;
  localparam int OFS_PWM = 8'h60;
  localparam int OFS_DIV = 8'h90;
  localparam logic [7:0] DIV_DEFAULT = 8'hff;

  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  localparam int CLK_NS = 20;
  localparam int QTR_NS = 80;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] QTR_LAST = 3'(QTR_CYC - 1);

  typedef enum {CBE_M_NONE, CBE_M_NV, CBE_M_LIVE} cbe_mode_t;
  typedef enum {CBE_L_IDLE, CBE_L_RX, CBE_L_TX, CBE_L_SKIP} cbe_lst_t;
  typedef enum {CBE_H_IDLE, CBE_H_START, CBE_H_BYTE, CBE_H_STOP} cbe_hst_t;

  // Factory image: every pin pulled up, divider at its default.
  function automatic logic [CFG_W-1:0] cbe_factory();
    logic [CFG_W-1:0] v;
    v = '0;
    for (int i = 0; i < CFG_BYTES; i++) begin
      if (i >= OFS_DRV && i < OFS_PWM && ((i - OFS_DRV) % DRV_MODES) == 0) begin
        v[8*i +: 8] = 8'hff;
      end
      if (i == OFS_DIV) begin
        v[8*i +: 8] = DIV_DEFAULT;
      end
    end
    return v;
  endfunction : cbe_factory

  localparam logic [CFG_W-1:0] FACTORY_CFG = cbe_factory();
endpackage : cbe_pkg
